// >>> skr_bank.sv
// skew control and watchdog recovery frequency registers with lock-out
`timescale 1ns/1ps
`include "skr_regs.svh"
module skr_bank #(
    parameter int REF_KHZ = 14318
) (
    input wire logic mclk, // 40 MHz clock
    input wire logic srst, // synchronous reset, high
    input wire logic [7:0] reg_addr, // register index from serial engine
    input wire logic [7:0] reg_wdata, // write byte
    input wire logic reg_wr, // write strobe, one cycle
    output logic [7:0] reg_rdata, // read byte of reg_addr, one cycle late
    input wire logic [4:0] strap_freq_select, // strap pins, asynchronous
    input wire logic ratio_override, // ratio override control bit
    input wire logic [4:0] soft_ratio_sel, // software ratio select field
    input wire logic watchdog_enable, // watchdog enable control bit
    input wire logic watchdog_expired, // timeout pulse from watchdog
    output logic [2:0] cpu_pair_skew_sel, // pair skew code
    output logic [1:0] diff_proc_skew_sel, // differential skew code
    output logic signed [11:0] cpu_pair_skew_ps, // pair offset in ps
    output logic signed [11:0] diff_proc_skew_ps, // differential offset in ps
    output logic [7:0] synth_n, // applied N divider
    output logic [6:0] synth_m, // applied M divider
    output logic synth_use_strap, // applied frequency from strap table
    output logic [4:0] ratio_sel, // applied ratio select
    output logic synth_retune, // one-cycle load of new frequency
    output logic sys_reset_pulse, // one-cycle system reset request
    output logic recovery_locked // locked recovery mode
);
    skr_pkg::skr_state_t s_q;
    skr_pkg::skr_state_t s_d;

    function automatic logic in_range(input logic [7:0] n, input logic [6:0] m);
        logic [31:0] f_num;
        logic [31:0] lo;
        logic [31:0] hi;
        f_num = 32'(n) * 32'(REF_KHZ);
        lo = `SKR_FREQ_MIN_KHZ * 32'(m);
        hi = `SKR_FREQ_MAX_KHZ * 32'(m);
        in_range = (m != 7'h00) && (f_num >= lo) && (f_num <= hi);
    endfunction

    always_comb begin
        logic [7:0] n_new;
        logic [6:0] m_new;
        logic nm_wr;
        n_new = s_q.rec_n;
        m_new = s_q.rec_m;
        nm_wr = 1'b0;
        s_d = s_q;
        s_d.retune = 1'b0;
        s_d.sys_reset = 1'b0;
        s_d.strap_s1 = strap_freq_select;
        s_d.strap_s2 = s_q.strap_s1;
        if (!s_q.strap_taken) begin
            s_d.strap_lat = s_q.strap_s2;
            s_d.strap_taken = 1'b1;
        end
        if (reg_wr) begin
            if (reg_addr == `SKR_OFF_SKEW) begin
                s_d.cpu_skew = reg_wdata[`SKR_CPU_SKEW_MSB:`SKR_CPU_SKEW_LSB];
                s_d.diff_skew = reg_wdata[`SKR_DIFF_SKEW_MSB:`SKR_DIFF_SKEW_LSB];
            end else if (reg_addr == `SKR_OFF_REC_N && s_q.mode == skr_pkg::SKR_MODE_NORMAL) begin
                n_new = reg_wdata;
                nm_wr = 1'b1;
            end else if (reg_addr == `SKR_OFF_REC_M && s_q.mode == skr_pkg::SKR_MODE_NORMAL) begin
                m_new = reg_wdata[`SKR_REC_M_MSB:0];
                s_d.rec_src = reg_wdata[`SKR_REC_SRC_BIT];
                nm_wr = 1'b1;
            end
        end
        s_d.rec_n = n_new;
        s_d.rec_m = m_new;
        case (s_q.mode)
            skr_pkg::SKR_MODE_NORMAL: begin
                if (watchdog_expired && watchdog_enable) begin
                    s_d.mode = skr_pkg::SKR_MODE_LOCKED;
                    s_d.sys_reset = 1'b1;
                    s_d.retune = 1'b1;
                    if (s_q.rec_src && in_range(s_q.rec_n, s_q.rec_m)) begin
                        s_d.pll_n = s_q.rec_n;
                        s_d.pll_m = s_q.rec_m;
                        s_d.pll_strap = 1'b0;
                    end else begin
                        s_d.pll_strap = 1'b1;
                    end
                end else if (nm_wr && in_range(n_new, m_new)) begin
                    s_d.pll_n = n_new;
                    s_d.pll_m = m_new;
                    s_d.pll_strap = 1'b0;
                    s_d.retune = 1'b1;
                end
            end
            skr_pkg::SKR_MODE_LOCKED: begin
                if (!watchdog_enable) begin
                    s_d.mode = skr_pkg::SKR_MODE_NORMAL;
                end
            end
            default: s_d.mode = skr_pkg::SKR_MODE_NORMAL;
        endcase
        s_d.ratio = ratio_override ? soft_ratio_sel : s_q.strap_lat;
        case (s_q.cpu_skew)
            3'h0: s_d.cpu_ps = 12'sh000;
            3'h1: s_d.cpu_ps = -`SKR_SKEW_STEP_PS;
            3'h2: s_d.cpu_ps = -(`SKR_SKEW_STEP_PS * 12'sh002);
            3'h3: s_d.cpu_ps = -(`SKR_SKEW_STEP_PS * 12'sh003);
            default: s_d.cpu_ps = `SKR_SKEW_STEP_PS * $signed({10'h000, s_q.cpu_skew[1:0] + 2'h1});
        endcase
        if (s_q.cpu_skew[2] && s_q.cpu_skew[1:0] == 2'h3) begin
            s_d.cpu_ps = `SKR_SKEW_STEP_PS * 12'sh004;
        end
        case (s_q.diff_skew)
            2'h0: s_d.diff_ps = 12'sh000;
            2'h1: s_d.diff_ps = -`SKR_SKEW_STEP_PS;
            2'h2: s_d.diff_ps = `SKR_SKEW_STEP_PS;
            default: s_d.diff_ps = `SKR_SKEW_STEP_PS * 12'sh002;
        endcase
        if (reg_addr == `SKR_OFF_SKEW) begin
            s_d.rdata = {s_q.cpu_skew, 3'h0, s_q.diff_skew};
        end else if (reg_addr == `SKR_OFF_REC_N) begin
            s_d.rdata = s_q.rec_n;
        end else if (reg_addr == `SKR_OFF_REC_M) begin
            s_d.rdata = {s_q.rec_src, s_q.rec_m};
        end else begin
            s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
            // strap synchroniser keeps running so the latch after release sees settled pins
            s_q.strap_s1 <= s_d.strap_s1;
            s_q.strap_s2 <= s_d.strap_s2;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign cpu_pair_skew_sel = s_q.cpu_skew;
    assign diff_proc_skew_sel = s_q.diff_skew;
    assign cpu_pair_skew_ps = s_q.cpu_ps;
    assign diff_proc_skew_ps = s_q.diff_ps;
    assign synth_n = s_q.pll_n;
    assign synth_m = s_q.pll_m;
    assign synth_use_strap = s_q.pll_strap;
    assign ratio_sel = s_q.ratio;
    assign synth_retune = s_q.retune;
    assign sys_reset_pulse = s_q.sys_reset;
    assign recovery_locked = (s_q.mode == skr_pkg::SKR_MODE_LOCKED);

    sequence s_expire;
        watchdog_expired && watchdog_enable && !recovery_locked;
    endsequence
    sequence s_recover;
        sys_reset_pulse && synth_retune && recovery_locked;
    endsequence

    property p_cpu_skew_max;
        @(posedge mclk) disable iff (srst)
        cpu_pair_skew_sel == 3'h7 |=> cpu_pair_skew_ps == 12'sd600;
    endproperty
    a_cpu_skew_max: assert property (p_cpu_skew_max) else $error("pair skew 111 not +600");

    property p_cpu_skew_neg;
        @(posedge mclk) disable iff (srst)
        cpu_pair_skew_sel == 3'h3 |=> cpu_pair_skew_ps == -12'sd450;
    endproperty
    a_cpu_skew_neg: assert property (p_cpu_skew_neg) else $error("pair skew 011 not -450");

    property p_diff_skew;
        @(posedge mclk) disable iff (srst)
        diff_proc_skew_sel == 2'h3 |=> diff_proc_skew_ps == 12'sd300;
    endproperty
    a_diff_skew: assert property (p_diff_skew) else $error("diff skew 11 not +300");

    property p_expire_locks;
        @(posedge mclk) disable iff (srst)
        s_expire |=> s_recover;
    endproperty
    a_expire_locks: assert property (p_expire_locks) else $error("expiry did not recover");

    property p_src_strap;
        @(posedge mclk) disable iff (srst)
        s_expire ##0 !s_q.rec_src |=> synth_use_strap;
    endproperty
    a_src_strap: assert property (p_src_strap) else $error("recovery ignored source");

    property p_locked_hold;
        @(posedge mclk) disable iff (srst)
        recovery_locked && watchdog_enable |=> $stable(synth_n) && $stable(synth_m) && !synth_retune;
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("retune while locked");

    property p_write_retunes;
        @(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == `SKR_OFF_REC_N && !recovery_locked && !watchdog_expired
            && in_range(reg_wdata, s_q.rec_m) |=> synth_retune && synth_n == $past(reg_wdata);
    endproperty
    a_write_retunes: assert property (p_write_retunes) else $error("N write no retune");

    property p_range;
        @(posedge mclk) disable iff (srst)
        synth_retune && !synth_use_strap |-> in_range(synth_n, synth_m);
    endproperty
    a_range: assert property (p_range) else $error("frequency out of range");

    property p_ratio;
        @(posedge mclk) disable iff (srst)
        ratio_override |=> ratio_sel == $past(soft_ratio_sel);
    endproperty
    a_ratio: assert property (p_ratio) else $error("override ratio not used");

    property p_reserved;
        @(posedge mclk) disable iff (srst)
        reg_addr == `SKR_OFF_SKEW |=> reg_rdata[4:2] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule

// >>> skr_regs.svh
// register offsets, field positions, reset values and limits of the skew and recovery bank
`ifndef SKR_REGS_SVH
`define SKR_REGS_SVH
`define SKR_OFF_SKEW 8'h0A
`define SKR_OFF_REC_N 8'h0B
`define SKR_OFF_REC_M 8'h0C
`define SKR_CPU_SKEW_MSB 7
`define SKR_CPU_SKEW_LSB 5
`define SKR_DIFF_SKEW_MSB 1
`define SKR_DIFF_SKEW_LSB 0
`define SKR_REC_SRC_BIT 7
`define SKR_REC_M_MSB 6
`define SKR_RST_SKEW 8'h00
`define SKR_RST_REC_N 8'h00
`define SKR_RST_REC_M 8'h00
`define SKR_SKEW_STEP_PS 12'sh096
`define SKR_FREQ_MIN_KHZ 32'h0000C350
`define SKR_FREQ_MAX_KHZ 32'h0003C8C0
`endif

// >>> skr_pkg.sv
// types of the skew and recovery register bank
package skr_pkg;
    typedef enum logic {
        SKR_MODE_NORMAL = 1'b0,
        SKR_MODE_LOCKED = 1'b1
    } skr_mode_t;

    typedef struct packed {
        logic [4:0] strap_s1;
        logic [4:0] strap_s2;
        logic [4:0] strap_lat;
        logic strap_taken;
        logic [2:0] cpu_skew;
        logic [1:0] diff_skew;
        logic [7:0] rec_n;
        logic [6:0] rec_m;
        logic rec_src;
        skr_mode_t mode;
        logic [7:0] pll_n;
        logic [6:0] pll_m;
        logic pll_strap;
        logic retune;
        logic sys_reset;
        logic [4:0] ratio;
        logic [7:0] rdata;
        logic signed [11:0] cpu_ps;
        logic signed [11:0] diff_ps;
    } skr_state_t;
endpackage

// >>> skr_host.sv
// host side model: byte writes and reads of the register bank
`timescale 1ns/1ps
module skr_host (
    input wire logic mclk, // clock
    output logic [7:0] reg_addr, // register index
    output logic [7:0] reg_wdata, // write byte
    output logic reg_wr, // write strobe
    input wire logic [7:0] reg_rdata // read byte
);
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // strobe stays high across a burst; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit last);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        if (last) begin
            @(posedge mclk);
            reg_wr <= 1'b0;
            reg_wdata <= ~d;
        end
    endtask
    task automatic wr_nm(input logic [7:0] n, input logic [7:0] m);
        wr(8'h0B, n, 1'b0);
        wr(8'h0C, m, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        @(negedge mclk);
        d = reg_rdata;
    endtask
endmodule

// >>> skr_bank_test.sv
// self-checking bench of the skew and recovery register bank
`timescale 1ns/1ps
module skr_bank_test;
    logic mclk, srst, ratio_override, watchdog_enable, watchdog_expired, reg_wr;
    logic synth_use_strap, synth_retune, sys_reset_pulse, recovery_locked;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, synth_n, rv, an;
    logic [4:0] strap_freq_select, soft_ratio_sel, ratio_sel;
    logic [2:0] cpu_pair_skew_sel;
    logic [1:0] diff_proc_skew_sel;
    logic signed [11:0] cpu_pair_skew_ps, diff_proc_skew_ps;
    logic [6:0] synth_m, am, rm;
    int failures, samples_checked, n_ret, n_rst, e_ret, e_rst, cyc;
    skr_bank uut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
        .strap_freq_select, .ratio_override, .soft_ratio_sel, .watchdog_enable,
        .watchdog_expired, .cpu_pair_skew_sel, .diff_proc_skew_sel, .cpu_pair_skew_ps,
        .diff_proc_skew_ps, .synth_n, .synth_m, .synth_use_strap, .ratio_sel,
        .synth_retune, .sys_reset_pulse, .recovery_locked);
    skr_host host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // pulse counters, so a pulse landing inside a burst is not missed
    always @(negedge mclk) begin
        n_ret += synth_retune;
        n_rst += sys_reset_pulse;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic signed [11:0] cps(input logic [2:0] c);
        return c == 0 ? 0 : c < 4 ? -150 * int'(c) : 150 * (int'(c) - 3);
    endfunction
    function automatic logic signed [11:0] dps(input logic [1:0] d);
        return d == 0 ? 0 : d == 1 ? -150 : 150 * (int'(d) - 1);
    endfunction
    function automatic int inr(input int n, input int m);
        return m != 0 && n * 14318 >= 50000 * m && n * 14318 <= 248000 * m;
    endfunction
    task automatic cnt(input int r, input int s);
        repeat (4) @(posedge mclk);
        chk("retunes", n_ret - e_ret, r);
        chk("resets", n_rst - e_rst, s);
        e_ret = n_ret;
        e_rst = n_rst;
    endtask
    task automatic wnm(input logic [7:0] n, input logic [7:0] m);
        int r;
        r = inr(n, rm) + inr(n, m[6:0]);
        if (inr(n, rm)) {an, am} = {n, rm};
        if (inr(n, m[6:0])) {an, am} = {n, m[6:0]};
        rm = m[6:0];
        host.wr_nm(n, m);
        cnt(r, 0);
        chk("nm", {synth_n, synth_m}, {an, am});
    endtask
    task automatic expire;
        @(posedge mclk);
        watchdog_expired <= 1'b1;
        @(posedge mclk);
        watchdog_expired <= 1'b0;
    endtask
    initial begin
        void'($urandom(78981));
        srst = 1'b1;
        ratio_override = 1'b0;
        watchdog_enable = 1'b0;
        watchdog_expired = 1'b0;
        strap_freq_select = 5'($urandom);
        soft_ratio_sel = 5'($urandom);
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk("rst", {synth_n, synth_retune, sys_reset_pulse, recovery_locked}, 0);
        for (int a = 10; a < 14; a++) begin
            host.rd(a[7:0], rv);
            chk("rst rd", rv, 0);
        end
        chk("strap ratio", ratio_sel, strap_freq_select);
        @(posedge mclk);
        ratio_override <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("soft ratio", ratio_sel, soft_ratio_sel);
        $display("reset and ratio done");
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h0A, {i[2:0], 3'b111, i[1:0]}, 1);
            host.rd(8'h0A, rv);
            chk("skew rd", rv, {i[2:0], 3'b000, i[1:0]});
            chk("codes", {cpu_pair_skew_sel, diff_proc_skew_sel}, {i[2:0], i[1:0]});
            chk("cpu ps", cpu_pair_skew_ps, cps(i[2:0]));
            chk("diff ps", diff_proc_skew_ps, dps(i[1:0]));
        end
        $display("skew done");
        host.wr(8'h0B, 8'h64, 1);
        cnt(0, 0);
        host.wr(8'h0C, 8'h0A, 1);
        cnt(1, 0);
        {an, am, rm} = {8'h64, 7'h0A, 7'h0A};
        host.wr(8'h0B, 8'hC8, 1);
        cnt(0, 0);
        host.rd(8'h0B, rv);
        chk("n stored", {rv, synth_n}, {8'hC8, an});
        repeat (16) wnm(8'($urandom), {1'($urandom), 7'($urandom_range(1, 127))});
        $display("divider writes done");
        wnm(8'h64, 8'h8A);
        expire();
        cnt(0, 0);
        watchdog_enable <= 1'b1;
        expire();
        cnt(1, 1);
        chk("rec", {recovery_locked, synth_use_strap, synth_n, synth_m}, 17'h1320A);
        host.wr(8'h0B, 8'h50, 1);
        expire();
        cnt(0, 0);
        host.rd(8'h0B, rv);
        chk("locked n", rv, 8'h64);
        @(posedge mclk);
        watchdog_enable <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("unlock", recovery_locked, 1'b0);
        wnm(8'h64, 8'h0A);
        watchdog_enable <= 1'b1;
        expire();
        cnt(1, 1);
        chk("strap src", {recovery_locked, synth_use_strap}, 2'b11);
        $display("watchdog done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk("rst2", {synth_n, synth_use_strap, recovery_locked, cpu_pair_skew_sel}, 0);
        @(posedge mclk);
        ratio_override <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("strap again", ratio_sel, strap_freq_select);
        $display("second reset done");
        wrap_up();
    end
endmodule
